/* core/sarf_regfiles.sv */
// address and scalar operating register files with intermediate buffers
//
// Summary of operation
// - eight 24-bit address registers for addressing, indexing, shifts, loops
// - address registers selected by a 3-bit index 0 to 7
// - one address write per clock; colliding arrivals hold issue
// - issue reserves the target address register until its value lands
// - addr_reg_zero feeds address branch tests and block move counts
// - sixty-four 24-bit address buffers selected by a 6-bit index
// - address register to buffer move takes one clock
// - block moves one word per clock, no buffer reservation, issue blocked
// - return jump stores next parcel in return_link_buffer, then branches
// - branch via buffer loads parcel address from return_link_buffer
// - buffers reached only by primary register moves, memory and the return link
// - address registers take count results and supply shift counts
// - vector length and exchange address load only from address registers
// - paths memory to address, via buffers, and address to scalar
// - eight 64-bit scalar registers for integer and floating work
// - scalar registers supply vector operands and element moves
// - scalar registers carry vector mask, cycle counter, interval values
// - one scalar write per clock; colliding arrivals hold issue
// - issue reserves the target scalar register until written
// - scalar_reg_zero feeds the scalar branch tests
// - sixty-four 64-bit scalar buffers, one clock moves
`timescale 1ns/1ps
`default_nettype none
module sarf_regfiles
    import sarf_pkg::*;
(
    input  wire logic              core_clk,      // cpu clock
    input  wire logic              arst_n,        // async reset, low
    input  wire logic              reqValid,      // issue request present
    input  wire logic [NREG-1:0]   reqRdA,        // address regs read
    input  wire logic [NREG-1:0]   reqRdS,        // scalar regs read
    input  wire logic              reqDstA,       // writes address reg
    input  wire logic [RIDX_W-1:0] reqIdxA,       // address target
    input  wire logic [LAT_W-1:0]  reqLatA,       // clocks to arrival
    input  wire sarf_src_t         reqSrcA,       // arrival source
    input  wire logic [BIDX_W-1:0] reqSubA,       // buffer or xfer index
    input  wire logic              reqDstS,       // writes scalar reg
    input  wire logic [RIDX_W-1:0] reqIdxS,       // scalar target
    input  wire logic [LAT_W-1:0]  reqLatS,       // clocks to arrival
    input  wire sarf_src_t         reqSrcS,       // arrival source
    input  wire logic [BIDX_W-1:0] reqSubS,       // buffer or xfer index
    output logic                   issueOk,       // request may issue
    input  wire logic [A_W-1:0]    aExtData,      // unit/memory result
    input  wire logic [S_W-1:0]    sExtData,      // unit/memory result
    output logic                   aWrTake,       // address file written
    output logic                   sWrTake,       // scalar file written
    input  wire logic [RIDX_W-1:0] aRdIdxJ,       // read port j
    input  wire logic [RIDX_W-1:0] aRdIdxK,       // read port k
    input  wire logic [RIDX_W-1:0] sRdIdxJ,       // read port j
    input  wire logic [RIDX_W-1:0] sRdIdxK,       // read port k
    output logic [A_W-1:0]         aRdDataJ,      // address j data
    output logic [A_W-1:0]         aRdDataK,      // address k data
    output logic [S_W-1:0]         sRdDataJ,      // scalar j data
    output logic [S_W-1:0]         sRdDataK,      // scalar k data
    output logic [FLG_W-1:0]       addrZeroFlags, // branch tests
    output logic [FLG_W-1:0]       scalZeroFlags, // branch tests
    input  wire logic              abMove,        // address to buffer
    input  wire logic [RIDX_W-1:0] abSrc,         // source register
    input  wire logic [BIDX_W-1:0] abDst,         // buffer index
    input  wire logic              stMove,        // scalar to buffer
    input  wire logic [RIDX_W-1:0] stSrc,         // source register
    input  wire logic [BIDX_W-1:0] stDst,         // buffer index
    input  wire logic              blkStart,      // start block move
    input  wire logic              blkToMem,      // 1 buffer->memory
    input  wire logic              blkScalar,     // 1 scalar buffers
    input  wire logic [BIDX_W-1:0] blkFirst,      // first buffer
    input  wire logic              memRdValid,    // memory word in
    input  wire logic [S_W-1:0]    memRdData,     // memory data
    input  wire logic              memWrReady,    // memory takes word
    output logic                   memWrValid,    // word to memory
    output logic [S_W-1:0]         memWrData,     // data to memory
    output logic                   blkBusy,       // block move running
    input  wire logic              retJump,       // return jump
    input  wire logic [A_W-1:0]    nextParcel,    // next parcel address
    input  wire logic [A_W-1:0]    jumpTarget,    // ijkm target
    input  wire logic              branchViaBuf,  // branch to link
    output logic                   pLoad,         // load parcel address
    output logic [A_W-1:0]         pAddr,         // new parcel address
    input  wire logic              vlLoad,        // load vector length
    input  wire logic              xaLoad,        // load exchange addr
    input  wire logic [RIDX_W-1:0] ctlSrc,        // source register
    output logic [VL_W-1:0]        vlOut,         // vector_length_reg
    output logic [XA_W-1:0]        xaOut,         // exchange_address_reg
    input  wire logic [SW_AW-1:0]  swAddr,        // software address
    input  wire logic [SW_DW-1:0]  swWrData,      // software data
    input  wire logic              swWr,          // write strobe
    input  wire logic              swRd,          // read strobe
    output logic [SW_DW-1:0]       swRdData       // read data
);

    function automatic logic [FLG_W-1:0] testFlags(
        input logic [S_W-1:0] d,
        input logic           sgn
    );
        logic [FLG_W-1:0] r;
        r = '0;
        r[FLG_ZERO]  = (d == '0);
        r[FLG_NONZ]  = (d != '0);
        r[FLG_POS]   = ~sgn;
        r[FLG_MINUS] = sgn;
        return r;
    endfunction : testFlags

    function automatic logic [S_W-1:0] regWord(
        input logic [NREG*S_W-1:0] flat,
        input logic [RIDX_W-1:0]   idx
    );
        return flat[idx*S_W +: S_W];
    endfunction : regWord

    localparam logic [S_W-1:0] A_MASK = {{(S_W-A_W){1'b0}}, {A_W{1'b1}}};

    // per-file views: index 0 address side, 1 scalar side
    logic [NREG-1:0]   reqRd    [2];
    logic              reqDst   [2];
    logic [RIDX_W-1:0] reqIdx   [2];
    logic [LAT_W-1:0]  reqLat   [2];
    sarf_src_t         reqSrc   [2];
    logic [BIDX_W-1:0] reqSub   [2];
    logic [S_W-1:0]    extData  [2];
    logic [S_W-1:0]    xferIn   [2];
    logic [RIDX_W-1:0] rdIdxJ   [2];
    logic [RIDX_W-1:0] rdIdxK   [2];
    logic              mvEn     [2];
    logic [RIDX_W-1:0] mvSrc    [2];
    logic [BIDX_W-1:0] mvDst    [2];
    logic              blkWr    [2];
    logic              rjEn     [2];
    logic [NREG*S_W-1:0] regsFlat [2];
    logic [NREG-1:0]   resv     [2];
    logic              hazard   [2];
    logic              wrTake   [2];
    logic              pend     [2];
    logic [BIDX_W-1:0] sub0     [2];
    logic [S_W-1:0]    rdJ      [2];
    logic [S_W-1:0]    rdK      [2];
    logic [FLG_W-1:0]  zflags   [2];
    logic [S_W-1:0]    bufAtPtr [2];
    logic [S_W-1:0]    linkWord [2];

    logic              ctrlHold_ff;
    logic              clrPulse;
    logic              issued;
    sarf_blk_t         blkState_ff;
    sarf_blk_t         nxt_blkState;
    logic [BIDX_W-1:0] blkPtr_ff;
    logic [CNT_W-1:0]  blkRem_ff;
    logic              blkMem_ff;
    logic              blkSel_ff;
    logic              memWrValid_ff;
    logic [S_W-1:0]    memWrData_ff;
    logic              wrSlotFree;
    logic              blkStep;
    logic              pLoad_ff;
    logic [A_W-1:0]    pAddr_ff;
    logic [VL_W-1:0]   vl_ff;
    logic [XA_W-1:0]   xa_ff;
    logic [S_W-1:0]    ctlWord;
    logic [SW_DW-1:0]  swRdData_ff;
    logic [SW_DW-1:0]  statWord;
    logic [SW_DW-1:0]  nxt_swRdData;

    assign reqRd[0]   = reqRdA;
    assign reqRd[1]   = reqRdS;
    assign reqDst[0]  = reqDstA;
    assign reqDst[1]  = reqDstS;
    assign reqIdx[0]  = reqIdxA;
    assign reqIdx[1]  = reqIdxS;
    assign reqLat[0]  = reqLatA;
    assign reqLat[1]  = reqLatS;
    assign reqSrc[0]  = reqSrcA;
    assign reqSrc[1]  = reqSrcS;
    assign reqSub[0]  = reqSubA;
    assign reqSub[1]  = reqSubS;
    assign extData[0] = {{(S_W-A_W){1'b0}}, aExtData};
    assign extData[1] = sExtData;
    // address/scalar crossing reads the other file at the arriving index
    assign xferIn[0]  = regWord(regsFlat[1], sub0[0][RIDX_W-1:0]);
    assign xferIn[1]  = regWord(regsFlat[0], sub0[1][RIDX_W-1:0]);
    assign rdIdxJ[0]  = aRdIdxJ;
    assign rdIdxJ[1]  = sRdIdxJ;
    assign rdIdxK[0]  = aRdIdxK;
    assign rdIdxK[1]  = sRdIdxK;
    assign mvEn[0]    = abMove;
    assign mvEn[1]    = stMove;
    assign mvSrc[0]   = abSrc;
    assign mvSrc[1]   = stSrc;
    assign mvDst[0]   = abDst;
    assign mvDst[1]   = stDst;
    assign blkStep    = (blkState_ff == BLK_RUN) & ~blkMem_ff & memRdValid
                        & (blkRem_ff != '0);
    assign blkWr[0]   = blkStep & ~blkSel_ff;
    assign blkWr[1]   = blkStep & blkSel_ff;
    assign rjEn[0]    = retJump;
    assign rjEn[1]    = 1'b0;

    assign clrPulse = swWr & (swAddr == OFF_CTRL) & swWrData[CTRL_CLR_BIT];
    assign blkBusy  = (blkState_ff != BLK_IDLE);
    assign issueOk  = ~hazard[0] & ~hazard[1] & ~blkBusy & ~ctrlHold_ff;
    assign issued   = reqValid & issueOk;

    for (genvar f = 0; f < 2; f++)
    begin : g_file
        localparam logic [S_W-1:0] WMASK = (f == 0) ? A_MASK : '1;
        localparam int             SGN   = (f == 0) ? A_W - 1 : S_W - 1;

        logic [S_W-1:0]    regs_ff   [NREG];
        logic [S_W-1:0]    bufMem_ff [NBUF];
        logic [NREG-1:0]   resv_ff;
        logic [NREG-1:0]   nxt_resv;
        logic [CAL_D-1:0]  calV_ff;
        logic [CAL_D-1:0]  nxt_calV;
        logic [RIDX_W-1:0] calIdx_ff [CAL_D];
        logic [RIDX_W-1:0] nxt_calIdx [CAL_D];
        sarf_src_t         calSrc_ff [CAL_D];
        sarf_src_t         nxt_calSrc [CAL_D];
        logic [BIDX_W-1:0] calSub_ff [CAL_D];
        logic [BIDX_W-1:0] nxt_calSub [CAL_D];
        logic              wrEn;
        logic [S_W-1:0]    wrData;
        logic [S_W-1:0]    nxt_zero;
        logic              bWrEn;
        logic [BIDX_W-1:0] bWrIdx;
        logic [S_W-1:0]    bWrData;
        logic [FLG_W-1:0]  flags_ff;
        logic [S_W-1:0]    rdJ_ff;
        logic [S_W-1:0]    rdK_ff;
        logic              take;

        // slot n of the calendar holds the write landing n clocks ahead
        assign wrEn    = calV_ff[0];
        assign sub0[f] = calSub_ff[0];
        assign wrData  = WMASK & ((calSrc_ff[0] == SRC_BUF)
                         ? bufMem_ff[calSub_ff[0]]
                         : (calSrc_ff[0] == SRC_XFER) ? xferIn[f]
                         : extData[f]);
        assign hazard[f] = reqValid & ((|(reqRd[f] & resv_ff))
                           | (reqDst[f] & (resv_ff[reqIdx[f]]
                           | calV_ff[reqLat[f]]
                           | (reqLat[f] == LAT_NONE))));
        assign take = issued & reqDst[f];
        assign nxt_resv = (resv_ff & ~(wrEn ? (NREG'(1) << calIdx_ff[0])
                          : '0))
                          | (take ? (NREG'(1) << reqIdx[f]) : '0);

        for (genvar n = 0; n < CAL_D; n++)
        begin : g_slot
            logic land;
            assign land = take & ({1'b0, reqLat[f]} == 5'(n + 1));
            if (n == CAL_D - 1)
            begin : g_top
                assign nxt_calV[n]   = land;
                assign nxt_calIdx[n] = reqIdx[f];
                assign nxt_calSrc[n] = reqSrc[f];
                assign nxt_calSub[n] = reqSub[f];
            end
            else
            begin : g_mid
                assign nxt_calV[n]   = land | calV_ff[n+1];
                assign nxt_calIdx[n] = land ? reqIdx[f] : calIdx_ff[n+1];
                assign nxt_calSrc[n] = land ? reqSrc[f] : calSrc_ff[n+1];
                assign nxt_calSub[n] = land ? reqSub[f] : calSub_ff[n+1];
            end
        end

        always_ff @(posedge core_clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                resv_ff <= '0;
                calV_ff <= '0;
            end
            else if (clrPulse)
            begin
                resv_ff <= '0;
                calV_ff <= '0;
            end
            else
            begin
                resv_ff <= nxt_resv;
                calV_ff <= nxt_calV;
            end
        end

        always_ff @(posedge core_clk)
        begin
            calIdx_ff <= nxt_calIdx;
            calSrc_ff <= nxt_calSrc;
            calSub_ff <= nxt_calSub;
        end

        // single write port: only the arriving calendar slot writes
        always_ff @(posedge core_clk or negedge arst_n)
        begin
            if (!arst_n)
                regs_ff <= '{default: '0};
            else if (wrEn)
                regs_ff[calIdx_ff[0]] <= wrData;
        end

        assign nxt_zero = (wrEn && calIdx_ff[0] == ZERO_REG)
                          ? wrData : regs_ff[ZERO_REG];

        always_ff @(posedge core_clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                flags_ff <= FLG_RST;
                rdJ_ff   <= '0;
                rdK_ff   <= '0;
            end
            else
            begin
                flags_ff <= testFlags(nxt_zero, nxt_zero[SGN]);
                rdJ_ff   <= regs_ff[rdIdxJ[f]];
                rdK_ff   <= regs_ff[rdIdxK[f]];
            end
        end

        // buffers see only moves, block transfers and the return link
        assign bWrEn   = rjEn[f] | blkWr[f] | mvEn[f];
        assign bWrIdx  = rjEn[f] ? LINK_BUF
                         : blkWr[f] ? blkPtr_ff : mvDst[f];
        assign bWrData = WMASK & (rjEn[f] ? {{(S_W-A_W){1'b0}}, nextParcel}
                         : blkWr[f] ? memRdData
                         : regs_ff[mvSrc[f]]);

        always_ff @(posedge core_clk)
        begin
            if (bWrEn)
                bufMem_ff[bWrIdx] <= bWrData;
        end

        for (genvar r = 0; r < NREG; r++)
        begin : g_flat
            assign regsFlat[f][r*S_W +: S_W] = regs_ff[r];
        end
        assign resv[f]     = resv_ff;
        assign pend[f]     = |calV_ff;
        assign wrTake[f]   = wrEn;
        assign rdJ[f]      = rdJ_ff;
        assign rdK[f]      = rdK_ff;
        assign zflags[f]   = flags_ff;
        assign bufAtPtr[f] = bufMem_ff[blkPtr_ff];
        assign linkWord[f] = bufMem_ff[LINK_BUF];
    end

    assign aWrTake       = wrTake[0];
    assign sWrTake       = wrTake[1];
    assign aRdDataJ      = rdJ[0][A_W-1:0];
    assign aRdDataK      = rdK[0][A_W-1:0];
    assign sRdDataJ      = rdJ[1];
    assign sRdDataK      = rdK[1];
    assign addrZeroFlags = zflags[0];
    assign scalZeroFlags = zflags[1];

    // block transfer engine, one word per clock at most
    assign wrSlotFree = ~memWrValid_ff | memWrReady;

    always_comb
    begin
        nxt_blkState = blkState_ff;
        case (blkState_ff)
            BLK_IDLE:
                if (blkStart)
                    nxt_blkState = BLK_RUN;
            BLK_RUN:
                if (blkRem_ff == '0 && (!blkMem_ff || wrSlotFree))
                    nxt_blkState = BLK_DONE;
            BLK_DONE:
                nxt_blkState = BLK_IDLE;
            default:
                nxt_blkState = BLK_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            blkState_ff   <= BLK_IDLE;
            blkPtr_ff     <= '0;
            blkRem_ff     <= '0;
            blkMem_ff     <= 1'b0;
            blkSel_ff     <= 1'b0;
            memWrValid_ff <= 1'b0;
            memWrData_ff  <= '0;
        end
        else if (clrPulse)
        begin
            blkState_ff   <= BLK_IDLE;
            blkRem_ff     <= '0;
            memWrValid_ff <= 1'b0;
        end
        else
        begin
            blkState_ff <= nxt_blkState;
            if (blkState_ff == BLK_IDLE && blkStart)
            begin
                blkPtr_ff <= blkFirst;
                blkRem_ff <= regsFlat[0][CNT_W-1:0];
                blkMem_ff <= blkToMem;
                blkSel_ff <= blkScalar;
            end
            else if (blkStep)
            begin
                blkPtr_ff <= blkPtr_ff + 1'b1;
                blkRem_ff <= blkRem_ff - 1'b1;
            end
            else if (blkState_ff == BLK_RUN && blkMem_ff && wrSlotFree)
            begin
                memWrValid_ff <= (blkRem_ff != '0);
                if (blkRem_ff != '0)
                begin
                    memWrData_ff <= bufAtPtr[blkSel_ff];
                    blkPtr_ff    <= blkPtr_ff + 1'b1;
                    blkRem_ff    <= blkRem_ff - 1'b1;
                end
            end
        end
    end

    assign memWrValid = memWrValid_ff;
    assign memWrData  = memWrData_ff;

    // parcel address, vector length and exchange address loads
    assign ctlWord = regWord(regsFlat[0], ctlSrc);

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pLoad_ff <= 1'b0;
            pAddr_ff <= '0;
            vl_ff    <= '0;
            xa_ff    <= '0;
        end
        else
        begin
            pLoad_ff <= retJump | branchViaBuf;
            if (retJump)
                pAddr_ff <= jumpTarget;
            else if (branchViaBuf)
                pAddr_ff <= linkWord[0][A_W-1:0];
            if (vlLoad)
                vl_ff <= ctlWord[VL_W-1:0];
            if (xaLoad)
                xa_ff <= ctlWord[XA_W-1:0];
        end
    end

    assign pLoad = pLoad_ff;
    assign pAddr = pAddr_ff;
    assign vlOut = vl_ff;
    assign xaOut = xa_ff;

    // software port
    assign statWord = {{(SW_DW-STAT_PEND_BIT-1){1'b0}}, pend[0] | pend[1],
                       blkBusy, resv[1], resv[0]};
    assign nxt_swRdData = !swRd ? '0
                          : (swAddr == OFF_CTRL)
                            ? {{(SW_DW-CTRL_HOLD_BIT-1){1'b0}}, ctrlHold_ff,
                               1'b0}
                          : (swAddr == OFF_STAT) ? statWord
                          : (swAddr == OFF_BLK)
                            ? {{(SW_DW-CNT_W){1'b0}}, blkRem_ff}
                          : '0;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrlHold_ff <= CTRL_HOLD_RST;
            swRdData_ff <= '0;
        end
        else
        begin
            if (swWr && swAddr == OFF_CTRL)
                ctrlHold_ff <= swWrData[CTRL_HOLD_BIT];
            swRdData_ff <= nxt_swRdData;
        end
    end

    assign swRdData = swRdData_ff;

endmodule : sarf_regfiles
`default_nettype wire

/* core/sarf_pkg.sv */
// constants and types shared by the address and scalar register files
package sarf_pkg;
    localparam int A_W    = 24;
    localparam int S_W    = 64;
    localparam int NREG   = 8;
    localparam int NBUF   = 64;
    localparam int RIDX_W = 3;
    localparam int BIDX_W = 6;
    localparam int CAL_D  = 16;
    localparam int LAT_W  = 4;
    localparam int CNT_W  = 7;
    localparam int VL_W   = 7;
    localparam int XA_W   = 8;
    localparam int FLG_W  = 4;
    localparam int SW_AW  = 4;
    localparam int SW_DW  = 32;
    // software port byte offsets
    localparam logic [SW_AW-1:0] OFF_CTRL = 4'h0;
    localparam logic [SW_AW-1:0] OFF_STAT = 4'h4;
    localparam logic [SW_AW-1:0] OFF_BLK  = 4'h8;
    // field positions
    localparam int CTRL_CLR_BIT  = 0;
    localparam int CTRL_HOLD_BIT = 1;
    localparam int STAT_RESA_LSB = 0;
    localparam int STAT_RESS_LSB = 8;
    localparam int STAT_BUSY_BIT = 16;
    localparam int STAT_PEND_BIT = 17;
    localparam int FLG_ZERO      = 0;
    localparam int FLG_NONZ      = 1;
    localparam int FLG_POS       = 2;
    localparam int FLG_MINUS     = 3;
    // values after reset
    localparam logic              CTRL_HOLD_RST = 1'b0;
    localparam logic [FLG_W-1:0]  FLG_RST       = 4'h5;
    // implicit register and buffer numbers, no-latency code
    localparam logic [RIDX_W-1:0] ZERO_REG = 3'h0;
    localparam logic [BIDX_W-1:0] LINK_BUF = 6'h00;
    localparam logic [LAT_W-1:0]  LAT_NONE = 4'h0;
    typedef enum logic [1:0] {
        SRC_EXT  = 2'h0,
        SRC_BUF  = 2'h1,
        SRC_XFER = 2'h2
    } sarf_src_t;
    typedef enum logic [1:0] {
        BLK_IDLE = 2'h0,
        BLK_RUN  = 2'h1,
        BLK_DONE = 2'h3
    } sarf_blk_t;
endpackage : sarf_pkg

/* tb/sarf_monitor.sv */
// assertions on the register file ports
`timescale 1ns/1ps
`default_nettype none
module sarf_monitor (
    input wire logic core_clk, arst_n, reqValid, reqDstA, issueOk,
    input wire logic aWrTake, blkBusy, retJump, branchViaBuf, pLoad,
    input wire logic swRd, memWrValid, memWrReady,
    input wire logic [3:0] reqLatA,
    input wire logic [23:0] jumpTarget, pAddr,
    input wire logic [31:0] swRdData,
    input wire logic [63:0] memWrData
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire go = reqValid && issueOk && reqDstA;
    lat_zero_a:
        assert property (reqValid && reqDstA && reqLatA == 4'h0 |-> !issueOk)
        else $error("zero latency issued");
    arrive_slot_a:
        assert property (go && reqLatA == 4'h3 |-> ##3 aWrTake)
        else $error("write missed slot");
    blk_stall_a:
        assert property (blkBusy |-> !issueOk) else $error("issue in block");
    ret_jump_a:
        assert property (retJump |=> pLoad && pAddr == $past(jumpTarget))
        else $error("bad jump target");
    via_buf_a:
        assert property (branchViaBuf |=> pLoad) else $error("no load");
    no_load_a:
        assert property (!retJump && !branchViaBuf |=> !pLoad)
        else $error("stray load");
    mem_hold_a:
        assert property (memWrValid && !memWrReady |=> memWrValid
            && $stable(memWrData)) else $error("word dropped");
    rd_quiet_a:
        assert property (!swRd |=> swRdData == '0) else $error("stray data");
    cover property (go && reqLatA == 4'h3);
    cover property ($rose(blkBusy));
    cover property (memWrValid && memWrReady);
endmodule : sarf_monitor
bind sarf_regfiles sarf_monitor sarf_monitor_i (.*);
`default_nettype wire

/* tb/sarf_mem_model.sv */
// memory side of block moves, stalling every other cycle
`timescale 1ns/1ps
`default_nettype none
module sarf_mem_model (
    input  wire logic   core_clk,   // cpu clock
    input  wire logic   arst_n,     // reset, low
    output logic        memWrReady, // word taken
    output logic        memRdValid, // word offered
    output logic [63:0] memRdData   // data offered
);
    logic [31:0] cnt_ff;
    assign memRdValid = cnt_ff[0];
    assign memRdData  = {cnt_ff, ~cnt_ff};
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
            {memWrReady, cnt_ff} <= '0;
        else
            {memWrReady, cnt_ff} <= {~memWrReady, cnt_ff + 32'h1};
endmodule : sarf_mem_model
`default_nettype wire

/* tb/scalar_address_register_files_bench.sv */
// self-checking bench for the address and scalar register files
`timescale 1ns/1ps
`default_nettype none
module scalar_address_register_files_bench import sarf_pkg::*; ();
    logic core_clk, arst_n, reqValid, reqDstA, reqDstS, issueOk, aWrTake;
    logic sWrTake, abMove, stMove, blkStart, blkToMem, blkScalar, retJump;
    logic memRdValid, memWrReady, memWrValid, blkBusy, branchViaBuf, pLoad;
    logic vlLoad, xaLoad, swWr, swRd;
    logic [2:0] reqIdxA, reqIdxS, aRdIdxJ, aRdIdxK, sRdIdxJ, sRdIdxK;
    logic [2:0] abSrc, stSrc, ctlSrc;
    logic [3:0] reqLatA, reqLatS, addrZeroFlags, scalZeroFlags, swAddr;
    logic [5:0] reqSubA, reqSubS, abDst, stDst, blkFirst;
    logic [6:0] vlOut;
    logic [7:0] reqRdA, reqRdS, xaOut;
    logic [23:0] aExtData, aRdDataJ, aRdDataK, nextParcel, jumpTarget, pAddr;
    logic [31:0] swWrData, swRdData;
    logic [63:0] sExtData, sRdDataJ, sRdDataK, memRdData, memWrData;
    sarf_src_t reqSrcA, reqSrcS;
    int bad_count, num_checks;
    sarf_regfiles sarf_regfiles_i (.*);
    sarf_mem_model sarf_mem_model_i (.*);
    task chk(input logic [63:0] e, g);
        num_checks++;
        if (e !== g) begin
            bad_count++;
            $display("ERROR %0t exp %h got %h", $time, e, g);
        end
    endtask : chk
    task t_resv;
        @(posedge core_clk) {reqValid, reqDstA, reqIdxA, reqLatA, aExtData,
            aRdIdxJ} <= {2'b11, 3'h3, 4'h3, 24'habcdef, 3'h3};
        #1 chk(1, issueOk);
        @(posedge core_clk) {reqDstA, reqRdA} <= {1'b0, 8'h08};
        #1 chk(0, issueOk);
        @(posedge core_clk) {reqRdA, reqDstA, reqIdxA, reqLatA} <=
            {8'h00, 1'b1, 3'h2, 4'h1};
        #1 chk(0, issueOk);
        @(posedge core_clk) reqLatA <= 0;
        #1 chk(2'b01, {issueOk, aWrTake});
        @(posedge core_clk) {reqDstA, reqRdA} <= {1'b0, 8'h08};
        #1 chk(1, issueOk);
        @(posedge core_clk) reqValid <= 0;
        #1 chk(24'habcdef, aRdDataJ);
    endtask : t_resv
    task t_blk;
        @(posedge core_clk) {reqValid, reqDstA, reqDstS, reqIdxA, reqIdxS,
            reqLatA, reqLatS, reqRdA, aExtData, sExtData} <= {3'b111, 6'h0,
            8'h11, 8'h00, 24'h800001, 64'h8000_0100_0000_0000};
        @(posedge core_clk) reqValid <= 0;
        #1 chk(2'b11, {aWrTake, sWrTake});
        @(posedge core_clk);
        #1 chk(8'haa, {addrZeroFlags, scalZeroFlags});
        @(posedge core_clk) {abMove, abSrc, abDst} <= {1'b1, 3'h3, 6'h05};
        #1 chk(24'h800001, aRdDataK);
        chk(64'h8000_0100_0000_0000, sRdDataJ);
        @(posedge core_clk) {abMove, blkStart, blkToMem, blkFirst} <=
            {3'b011, 6'h05};
        @(posedge core_clk) blkStart <= 0;
        #1 chk(2'b10, {blkBusy, issueOk});
        for (int n = 0; n < 9 && !memWrValid; n++) @(negedge core_clk);
        chk(24'habcdef, memWrData[23:0]);
        for (int n = 0; n < 9 && blkBusy; n++) @(negedge core_clk);
        chk(1, issueOk);
    endtask : t_blk
    task t_ret;
        @(posedge core_clk) {retJump, nextParcel, jumpTarget, vlLoad,
            xaLoad} <= {1'b1, 24'h001234, 24'h005678, 2'b11};
        @(posedge core_clk) {retJump, branchViaBuf, vlLoad, xaLoad} <= 4'b0100;
        #1 chk({25'h1005678, 7'h01, 8'h01}, {pLoad, pAddr, vlOut, xaOut});
        @(posedge core_clk) branchViaBuf <= 0;
        #1 chk({pLoad, pAddr}, 25'h1001234);
    endtask : t_ret
    task t_sw;
        @(posedge core_clk) {swWr, swWrData, reqValid} <= {1'b1, 32'h2, 1'b1};
        @(posedge core_clk) {swWr, swRd, swAddr} <= {2'b01, 4'hc};
        #1 chk(0, issueOk);
        @(posedge core_clk) {swWr, swRd, swAddr, swWrData} <= {2'b10, 36'h0};
        #1 chk(0, swRdData);
        @(posedge core_clk) {swWr, reqValid} <= 2'b00;
        #1 chk(1, issueOk);
    endtask : t_sw
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        core_clk = 0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        #20000;
        bad_count++;
        end_of_test;
    end
    initial begin
        {reqValid, reqRdA, reqRdS, reqDstA, reqIdxA, reqLatA, reqSubA,
         reqDstS, reqIdxS, reqLatS, reqSubS, aExtData, sExtData} = '0;
        {aRdIdxJ, aRdIdxK, sRdIdxJ, sRdIdxK, abMove, abSrc, abDst, stMove,
         stSrc, stDst, blkStart, blkToMem, blkScalar, blkFirst} = '0;
        {retJump, nextParcel, jumpTarget, branchViaBuf, vlLoad, xaLoad,
         ctlSrc, swAddr, swWrData, swWr, swRd, arst_n} = '0;
        reqSrcA = SRC_EXT;
        reqSrcS = SRC_EXT;
        repeat (3) @(posedge core_clk);
        arst_n <= 1;
        t_resv;
        t_blk;
        t_ret;
        t_sw;
        end_of_test;
    end
endmodule : scalar_address_register_files_bench
`default_nettype wire
